// ### src/lmbc_pkg.sv
// Shared constants for the coprocessor-master to host-bus cycle converter.
// Assumes both ends run on the same clock, clk_i; the size decoder is combinational.
package lmbc_pkg;

  // Cycle length limits, counted in clocks from the clock of the strobe.
  localparam int unsigned MIN_CYCLE_CLKS = 2;
  localparam int unsigned MIN_SINGLE_CLKS = 3;
  localparam int unsigned BURST_FIRST_CLKS = 4;
  localparam int unsigned MAX_BURST_BEATS = 4;

  // Clock index inside a cycle at which ready or burst-ready may be raised, and the beat index of the last burst transfer.
  localparam logic [2:0] SINGLE_READY_IDX = 3'(MIN_SINGLE_CLKS - 2);
  localparam logic [2:0] BURST_READY_IDX = 3'(BURST_FIRST_CLKS - 2);
  localparam logic [2:0] LAST_BEAT_IDX = 3'(MAX_BURST_BEATS - 1);

  // Widths of the coprocessor bus.
  localparam int unsigned LANES = 4;
  localparam int unsigned WORD_ADDR_W = 30;

  // Transfer size codes on the host bus, {hi, lo}.
  localparam logic [1:0] SIZE_FOUR = 2'h0;
  localparam logic [1:0] SIZE_ONE = 2'h1;
  localparam logic [1:0] SIZE_TWO = 2'h2;
  localparam logic [1:0] SIZE_THREE = 2'h3;

  // Reset value of the host-side input synchronisers: all inactive.
  localparam logic [3:0] SYNC_IDLE = 4'hf;

  // Positions of the host-side inputs in the synchroniser vector.
  localparam int unsigned SY_ACK0 = 0;
  localparam int unsigned SY_ACK1 = 1;
  localparam int unsigned SY_TERM = 2;
  localparam int unsigned SY_ACCEPT = 3;

endpackage : lmbc_pkg

// ### src/lmbc_if.sv
// Coprocessor bus between the master end and the converter end.
// Assumes a single clock; every signal is sampled on its rising edge.
`timescale 1ns/1ps
`default_nettype none
interface lmbc_if;
  import lmbc_pkg::*;

  logic master_addr_strobe_n;
  logic write_read;
  logic [LANES-1:0] byte_lane_enable_n;
  logic [WORD_ADDR_W-1:0] word_addr;
  logic last_transfer_flag_n;
  logic master_ready_n;
  logic burst_ready_out_n;
  logic hold_grant;

  // The converter end answers and passes on the bus grant.
  modport dev (
    input master_addr_strobe_n,
    input write_read,
    input byte_lane_enable_n,
    input word_addr,
    input last_transfer_flag_n,
    output master_ready_n,
    output burst_ready_out_n,
    output hold_grant
  );

  // The coprocessor master end starts cycles.
  modport mst (
    output master_addr_strobe_n,
    output write_read,
    output byte_lane_enable_n,
    output word_addr,
    output last_transfer_flag_n,
    input master_ready_n,
    input burst_ready_out_n,
    input hold_grant
  );
endinterface : lmbc_if
`default_nettype wire

// ### src/lmbc_size_decode.sv
// Byte-lane enable to transfer size and low address decode.
// Assumes contiguous enabled lanes; a gap still gives the lowest lane and count.
`timescale 1ns/1ps
`default_nettype none
module lmbc_size_decode
  import lmbc_pkg::*;
(
  input wire logic [LANES-1:0] byte_lane_enable_n_i,
  output logic transfer_size_hi_o,
  output logic transfer_size_lo_o,
  output logic [1:0] addr_lo_o
);

  logic [2:0] count;
  logic [1:0] first;
  logic found;

  // Count the enabled lanes and find the lowest one, purely combinationally.
  always_comb begin
    count = 3'h0;
    first = 2'h0;
    found = 1'b0;
    for (int i = 0; i < LANES; i++) begin
      if (!byte_lane_enable_n_i[i]) begin
        count = count + 3'h1;
        if (!found) begin
          first = 2'(i);
          found = 1'b1;
        end
      end
    end
  end

  // A full word encodes as size zero; other counts encode as themselves.
  assign {transfer_size_hi_o, transfer_size_lo_o} =
    (count == 3'h4) ? SIZE_FOUR : count[1:0];
  assign addr_lo_o = first;

endmodule : lmbc_size_decode
`default_nettype wire

// ### src/lmbc_bridge.sv
// Converter end: turns coprocessor master cycles into host-bus strobes,
// generates waits, ready and burst-ready, and handshakes bursts.
// Assumes host-bus acknowledges come from outside and are synchronised here;
// the bus grant comes from the arbiter on the same clock.
`timescale 1ns/1ps
`default_nettype none
module lmbc_bridge
  import lmbc_pkg::*;
#(
  parameter int unsigned READ_EXTRA_WAIT = 0
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  lmbc_if.dev cop,
  input wire logic hold_grant_i,
  output logic converted_addr_strobe_n_o,
  output logic converted_data_strobe_n_o,
  output logic data_buffer_enable_out_n_o,
  output logic converted_read_write_o,
  output logic transfer_size_hi_o,
  output logic transfer_size_lo_o,
  output logic [31:0] host_addr_o,
  output logic host_oe_o,
  output logic early_cycle_select_n_o,
  output logic other_cycle_select_n_o,
  output logic cycle_select_oe_o,
  output logic burst_request_out_n_o,
  input wire logic burst_accept_in_n_i,
  input wire logic sync_termination_in_n_i,
  input wire logic port_size_ack_0_n_i,
  input wire logic port_size_ack_1_n_i
);

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_SECOND = 3'h1,
    ST_WAIT = 3'h3,
    ST_BURST = 3'h2,
    ST_HOLD = 3'h6
  } lmbc_state_t;

  // Clock index at which a read may first see ready.
  localparam logic [2:0] READ_READY_IDX =
    3'(MIN_SINGLE_CLKS - 2 + READ_EXTRA_WAIT);

  lmbc_state_t state_q;
  logic [2:0] cnt_q;
  logic [2:0] beats_q;
  logic wr_q;
  logic breq_q;
  logic rdy_q;
  logic burst_ready_out_q;
  logic ack_armed_q;
  logic as_q;
  logic ds_q;
  logic dben_q;
  logic rw_q;
  logic [3:0] sync1_q;
  logic [3:0] sync2_q;
  logic ack_n;
  logic term_n;
  logic accept_n;
  logic starting;
  logic ready_ok;
  logic [2:0] ready_idx;
  logic [1:0] addr_lo;
  lmbc_state_t end_state;

  ////////////////////////////////////////////////////////////////////////////
  // Host-bus inputs

  // Two flip-flops before any logic looks at the host-bus handshakes.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sync1_q <= SYNC_IDLE;
      sync2_q <= SYNC_IDLE;
    end else begin
      sync1_q <= {burst_accept_in_n_i, sync_termination_in_n_i,
                  port_size_ack_1_n_i, port_size_ack_0_n_i};
      sync2_q <= sync1_q;
    end
  end

  // Either port acknowledge pulls the combined ready low.
  assign ack_n = sync2_q[SY_ACK0] & sync2_q[SY_ACK1];
  assign term_n = sync2_q[SY_TERM];
  assign accept_n = sync2_q[SY_ACCEPT];

  ////////////////////////////////////////////////////////////////////////////
  // Cycle sequencing

  // A new cycle may begin from idle or during the write hold clock.
  assign starting = ((state_q == ST_IDLE) || (state_q == ST_HOLD)) &&
                    !cop.master_addr_strobe_n;
  assign ready_idx = wr_q ? SINGLE_READY_IDX : READ_READY_IDX;
  assign ready_ok = !rdy_q && !ack_n && ack_armed_q && (cnt_q >= ready_idx);
  assign end_state = wr_q ? ST_HOLD : ST_IDLE;

  // Cycle state, clock index, beat count and burst request.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
      cnt_q <= 3'h0;
      beats_q <= 3'h0;
      wr_q <= 1'b0;
      breq_q <= 1'b0;
    end else if (!hold_grant_i) begin
      state_q <= ST_IDLE;
      cnt_q <= 3'h0;
      beats_q <= 3'h0;
      breq_q <= 1'b0;
    end else begin
      if (cnt_q != 3'h7) begin
        cnt_q <= cnt_q + 3'h1;
      end
      unique case (state_q)
        ST_IDLE, ST_HOLD: begin
          if (starting) begin
            state_q <= ST_SECOND;
            cnt_q <= 3'h1;
            beats_q <= 3'h0;
            wr_q <= cop.write_read;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        ST_SECOND: begin
          state_q <= ST_WAIT;
          breq_q <= cop.last_transfer_flag_n;
        end
        ST_WAIT: begin
          if (rdy_q) begin
            state_q <= end_state;
            breq_q <= 1'b0;
          end else if (breq_q && !accept_n) begin
            state_q <= ST_BURST;
          end
        end
        ST_BURST: begin
          if (burst_ready_out_q) begin
            beats_q <= beats_q + 3'h1;
          end
          if (rdy_q) begin
            state_q <= end_state;
            breq_q <= 1'b0;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Ready generation

  // Ready and burst-ready are single-clock answers to the master.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdy_q <= 1'b0;
      burst_ready_out_q <= 1'b0;
      ack_armed_q <= 1'b1;
    end else begin
      // A held acknowledge is stale until it has been seen released once.
      ack_armed_q <= ack_n || (ack_armed_q && !rdy_q);
      rdy_q <= 1'b0;
      burst_ready_out_q <= 1'b0;
      if (hold_grant_i) begin
        unique case (state_q)
          ST_SECOND: begin
            // Only a single-transfer cycle may end this early.
            rdy_q <= ready_ok && !cop.last_transfer_flag_n;
          end
          ST_WAIT: begin
            // Without an accepted burst the memory answers plainly.
            rdy_q <= ready_ok && !(breq_q && !accept_n);
          end
          ST_BURST: begin
            if (!rdy_q && !term_n && (cnt_q >= BURST_READY_IDX)) begin
              if (!cop.last_transfer_flag_n ||
                  (beats_q + 3'(burst_ready_out_q) >= LAST_BEAT_IDX)) begin
                rdy_q <= 1'b1;
              end else begin
                burst_ready_out_q <= 1'b1;
              end
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Host strobes

  // Registered host strobes follow the master strobe, direction and ready.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      as_q <= 1'b0;
      ds_q <= 1'b0;
      dben_q <= 1'b0;
      rw_q <= 1'b1;
    end else if (!hold_grant_i) begin
      as_q <= 1'b0;
      ds_q <= 1'b0;
      dben_q <= 1'b0;
      rw_q <= 1'b1;
    end else if (starting) begin
      as_q <= 1'b1;
      dben_q <= 1'b1;
      ds_q <= !cop.write_read;
      rw_q <= !cop.write_read;
    end else if (state_q == ST_HOLD) begin
      dben_q <= 1'b0;
    end else if (rdy_q) begin
      as_q <= 1'b0;
      ds_q <= 1'b0;
      dben_q <= wr_q;
    end else if (state_q == ST_SECOND) begin
      ds_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  lmbc_size_decode u_size (
    .byte_lane_enable_n_i(cop.byte_lane_enable_n),
    .transfer_size_hi_o(transfer_size_hi_o),
    .transfer_size_lo_o(transfer_size_lo_o),
    .addr_lo_o(addr_lo)
  );

  // Host outputs drive only while the master holds the bus.
  assign host_oe_o = hold_grant_i;
  assign host_addr_o = {cop.word_addr, addr_lo};
  assign converted_addr_strobe_n_o = !as_q;
  assign converted_data_strobe_n_o = !ds_q;
  assign data_buffer_enable_out_n_o = !dben_q;
  assign converted_read_write_o = rw_q;
  assign early_cycle_select_n_o = cop.master_addr_strobe_n;
  assign other_cycle_select_n_o = cop.master_addr_strobe_n;
  assign cycle_select_oe_o = hold_grant_i;
  assign burst_request_out_n_o = !breq_q;
  assign cop.master_ready_n = !rdy_q;
  assign cop.burst_ready_out_n = !burst_ready_out_q;
  assign cop.hold_grant = hold_grant_i;

endmodule : lmbc_bridge
`default_nettype wire

// ### src/lmbc_master.sv
// Coprocessor master end: runs single, multiple and burst cycles.
// Assumes the converter end on the same clock answers through the interface.
`timescale 1ns/1ps
`default_nettype none
module lmbc_master
  import lmbc_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  lmbc_if.mst cop,
  input wire logic req_i,
  input wire logic req_write_i,
  input wire logic [WORD_ADDR_W-1:0] req_word_addr_i,
  input wire logic [LANES-1:0] req_lane_enable_n_i,
  input wire logic [2:0] req_beats_i,
  output logic busy_o,
  output logic beat_done_o,
  output logic done_o
);

  typedef enum logic [1:0] {
    MS_IDLE = 2'h0,
    MS_ADDR = 2'h1,
    MS_DATA = 2'h3
  } lmbc_mstate_t;

  lmbc_mstate_t state_q;
  logic [WORD_ADDR_W-1:0] addr_q;
  logic [LANES-1:0] lanes_q;
  logic [2:0] rem_q;
  logic write_q;
  logic burst_ok_q;
  logic beat_q;
  logic done_q;
  logic [2:0] beats;
  logic got_rdy;
  logic got_burst_ready_out;

  // Clamp the request to one to four transfers.
  assign beats = (req_beats_i == 3'h0) ? 3'h1 :
                 (req_beats_i > 3'(MAX_BURST_BEATS)) ? 3'(MAX_BURST_BEATS) :
                 req_beats_i;
  assign got_rdy = (state_q == MS_DATA) && !cop.master_ready_n;
  assign got_burst_ready_out = (state_q == MS_DATA) && !cop.burst_ready_out_n;

  ////////////////////////////////////////////////////////////////////////////
  // Cycle sequencing

  // Start, step and finish transfers; a lost grant abandons the request.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= MS_IDLE;
      addr_q <= '0;
      lanes_q <= '1;
      rem_q <= 3'h0;
      write_q <= 1'b0;
      burst_ok_q <= 1'b0;
    end else if (!cop.hold_grant) begin
      state_q <= MS_IDLE;
    end else begin
      unique case (state_q)
        MS_IDLE: begin
          if (req_i) begin
            state_q <= MS_ADDR;
            addr_q <= req_word_addr_i;
            lanes_q <= req_lane_enable_n_i;
            rem_q <= beats;
            write_q <= req_write_i;
            // Bursts start only on an 8-byte boundary.
            burst_ok_q <= (beats != 3'h1) && !req_word_addr_i[0];
          end
        end
        MS_ADDR: begin
          state_q <= MS_DATA;
        end
        MS_DATA: begin
          if (got_rdy || got_burst_ready_out) begin
            rem_q <= rem_q - 3'h1;
            addr_q <= addr_q + 30'h1;
          end
          if (got_rdy) begin
            // Ready with transfers left repeats as a single cycle.
            state_q <= (rem_q == 3'h1) ? MS_IDLE : MS_ADDR;
            burst_ok_q <= 1'b0;
          end
        end
        default: begin
          state_q <= MS_IDLE;
        end
      endcase
    end
  end

  // One-clock pulses for each finished transfer and the whole request.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      beat_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      beat_q <= got_rdy || got_burst_ready_out;
      done_q <= got_rdy && (rem_q == 3'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus outputs

  assign cop.master_addr_strobe_n = !(state_q == MS_ADDR);
  assign cop.write_read = write_q;
  assign cop.byte_lane_enable_n = lanes_q;
  assign cop.word_addr = addr_q;
  // Last flag marks a single cycle and the final burst transfer. It drops
  // while the last burst-ready, for the next-to-last transfer, is taken, so that the converter's
  // registered answer to the final transfer is ready and not burst-ready.
  assign cop.last_transfer_flag_n = !((state_q == MS_DATA) &&
    ((rem_q == 3'h1) || !burst_ok_q ||
     (got_burst_ready_out && (rem_q == 3'h2))));
  assign busy_o = (state_q != MS_IDLE);
  assign beat_done_o = beat_q;
  assign done_o = done_q;

endmodule : lmbc_master
`default_nettype wire

// ### testbench/lmbc_checker.sv
// Concurrent checks on the coprocessor bus between both ends.
// Assumes one clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module lmbc_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic master_addr_strobe_n,
  input wire logic master_ready_n,
  input wire logic burst_ready_out_n,
  input wire logic hold_grant
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);
  ////////////////////
  // No answer comes in the clock of the strobe or the one after.
  strobe_no_ready_a: assert property (
    !master_addr_strobe_n |-> master_ready_n && burst_ready_out_n)
    else $error("answer in strobe clock");
  single_min_a: assert property (
    !master_addr_strobe_n |=> master_ready_n && burst_ready_out_n)
    else $error("answer one clock after strobe");
  burst_first_a: assert property (
    !master_addr_strobe_n |-> ##2 burst_ready_out_n)
    else $error("burst data too early");
  // Ready and burst-ready never overlap; ready is a single pulse.
  answer_excl_a: assert property (
    master_ready_n || burst_ready_out_n)
    else $error("ready and burst-ready together");
  ready_pulse_a: assert property (
    !master_ready_n |=> master_ready_n)
    else $error("ready held two clocks");
  strobe_pulse_a: assert property (
    !master_addr_strobe_n |=> master_addr_strobe_n)
    else $error("strobe held two clocks");
  // A burst has at most three burst-ready beats, closed quickly by ready.
  burst_max_a: assert property (
    !burst_ready_out_n [*3] |=> burst_ready_out_n)
    else $error("too many burst beats");
  burst_end_a: assert property (
    $fell(burst_ready_out_n) |-> ##[1:3] !master_ready_n)
    else $error("burst not ended in time");
  // Without the grant nothing is answered.
  no_grant_a: assert property (
    !hold_grant |=> master_ready_n && burst_ready_out_n)
    else $error("answer without grant");
  // Main scenarios.
  cover property (!burst_ready_out_n);
  cover property (!master_ready_n ##1 !master_addr_strobe_n);
  cover property ($fell(hold_grant));
endmodule : lmbc_checker
`default_nettype wire

// ### testbench/tb.sv
// Self-checking bench: master end and converter end joined by the bus.
// Assumes a 250 MHz clock; the bench acts as memory controller.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lmbc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic hold_grant_i = 1'b1;
  logic req_i = 1'b0;
  logic req_write_i = 1'b0;
  logic [29:0] req_word_addr_i = 30'h0;
  logic [3:0] req_lane_enable_n_i = 4'h0;
  logic [2:0] req_beats_i = 3'h1;
  logic use0 = 1'b1, use1 = 1'b0, acc = 1'b0;
  logic acc_n = 1'b1, term_n = 1'b1, ack0_n = 1'b1, ack1_n = 1'b1;
  logic busy_o, beat_done_o, done_o, as_n, ds_n, db_n, rw, sz_hi, sz_lo;
  logic hoe, ecs_n, ocs_n, csoe, breq_n;
  logic [31:0] haddr;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  ////////////////////
  lmbc_if lmbc_if_i ();
  lmbc_master lmbc_master_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .cop(lmbc_if_i), .req_i(req_i), .req_write_i(req_write_i),
    .req_word_addr_i(req_word_addr_i),
    .req_lane_enable_n_i(req_lane_enable_n_i), .req_beats_i(req_beats_i),
    .busy_o(busy_o), .beat_done_o(beat_done_o), .done_o(done_o));
  lmbc_bridge lmbc_bridge_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .cop(lmbc_if_i), .hold_grant_i(hold_grant_i),
    .converted_addr_strobe_n_o(as_n), .converted_data_strobe_n_o(ds_n),
    .data_buffer_enable_out_n_o(db_n), .converted_read_write_o(rw),
    .transfer_size_hi_o(sz_hi), .transfer_size_lo_o(sz_lo),
    .host_addr_o(haddr), .host_oe_o(hoe), .early_cycle_select_n_o(ecs_n),
    .other_cycle_select_n_o(ocs_n), .cycle_select_oe_o(csoe),
    .burst_request_out_n_o(breq_n), .burst_accept_in_n_i(acc_n),
    .sync_termination_in_n_i(term_n), .port_size_ack_0_n_i(ack0_n),
    .port_size_ack_1_n_i(ack1_n));
  lmbc_checker lmbc_checker_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .master_addr_strobe_n(lmbc_if_i.master_addr_strobe_n),
    .master_ready_n(lmbc_if_i.master_ready_n),
    .burst_ready_out_n(lmbc_if_i.burst_ready_out_n),
    .hold_grant(lmbc_if_i.hold_grant));
  ////////////////////
  // Clock, memory responder and the cut-off for a hang.
  always #2 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    ack0_n <= as_n | !use0 | acc;
    ack1_n <= as_n | !use1 | acc;
    acc_n <= breq_n | !acc;
    term_n <= breq_n | !acc;
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      wrap_up();
    end
  end
  // Cycle selects mirror the master strobe; drivers follow the grant.
  always @(negedge clk_i) begin
    if (rst_n_i) begin
      chk(ecs_n, lmbc_if_i.master_addr_strobe_n);
      chk(ocs_n, lmbc_if_i.master_addr_strobe_n);
      chk({hoe, csoe}, {2{hold_grant_i}});
    end
  end
  ////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Size code and low address from the lowest enabled lane and the count.
  function automatic logic [3:0] exp_sz(input logic [3:0] ln);
    int lo, n;
    lo = 0;
    n = 0;
    for (int i = 3; i >= 0; i--) begin
      if (!ln[i]) begin
        lo = i;
        n++;
      end
    end
    return {2'(n), 2'(lo)};
  endfunction : exp_sz
  // One request; times are counted in clocks from the request's take.
  task automatic run(input logic wr, input logic [29:0] wa,
      input logic [3:0] ln, input logic [2:0] bt, input int xa,
      input int xb, input logic xq);
    int c, fin = -1, ta = -1, tas = -1, tds = -1, tdb = -1, tasr = -1;
    int tdbr = -1, tr = -1, tr1 = -1, tb1 = -1, na = 0, nr = 0, nb = 0;
    int nd = 0, nq = 0;
    logic pas = 1'b1, pds = 1'b1, pdb = 1'b1, rws = 1'b0;
    logic [3:0] szs = 4'h0;
    @(posedge clk_i);
    req_i <= 1'b1;
    req_write_i <= wr;
    req_word_addr_i <= wa;
    req_lane_enable_n_i <= ln;
    req_beats_i <= bt;
    @(posedge clk_i);
    req_i <= 1'b0;
    for (c = 0; c < 90 && (fin < 0 || c < fin + 3); c++) begin
      @(negedge clk_i);
      if (!lmbc_if_i.master_addr_strobe_n) begin
        na++;
        if (ta < 0) ta = c;
      end
      if (pas && !as_n && tas < 0) begin
        tas = c;
        rws = rw;
        szs = {sz_hi, sz_lo, haddr[1:0]};
      end
      if (!pas && as_n && tasr < 0) tasr = c;
      if (pds && !ds_n && tds < 0) tds = c;
      if (pdb && !db_n && tdb < 0) tdb = c;
      if (!pdb && db_n && tdbr < 0) tdbr = c;
      if (!lmbc_if_i.master_ready_n) begin
        nr++;
        tr = c;
        if (tr1 < 0) tr1 = c;
      end
      if (!lmbc_if_i.burst_ready_out_n) begin
        nb++;
        if (tb1 < 0) tb1 = c;
      end
      if (beat_done_o) nd++;
      if (!breq_n) nq++;
      if (done_o && fin < 0) fin = c;
      pas = as_n;
      pds = ds_n;
      pdb = db_n;
    end
    chk(nd, bt);
    chk(na, xa);
    chk(nr, xa);
    chk(nb, xb);
    chk(nq > 0, xq);
    chk(tas - ta, 1);
    chk(tdb, tas);
    chk(tds - tas, wr);
    chk(rws, !wr);
    chk(szs, exp_sz(ln));
    if (nb == 0) begin
      chk(tr1 - ta >= 2, 1);
      chk(tasr, tr1 + 1);
      chk(tdbr, tr1 + 1 + wr);
    end else begin
      chk(tb1 - ta >= 3, 1);
      chk(tr - tb1, nb);
    end
  endtask : run
  // Grant taken away in mid-cycle before the port 1 acknowledge has passed the synchronisers.
  task automatic grant_drop();
    @(posedge clk_i);
    use0 <= 1'b0;
    req_i <= 1'b1;
    req_write_i <= 1'b0;
    @(posedge clk_i);
    req_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    hold_grant_i <= 1'b0;
    repeat (2) @(negedge clk_i);
    chk({as_n, ds_n, db_n, breq_n, busy_o}, 5'h1e);
    @(posedge clk_i);
    hold_grant_i <= 1'b1;
    use0 <= 1'b1;
    repeat (3) @(posedge clk_i);
  endtask : grant_drop
  task automatic wrap_up();
    if (num_errors == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  ////////////////////
  // Main sequence.
  initial begin
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(negedge clk_i);
    chk({as_n, ds_n, db_n, rw, breq_n}, 5'h1f);
    run(1'b0, 30'h40, 4'h0, 3'h1, 1, 0, 1'b0);
    run(1'b1, 30'h41, 4'he, 3'h1, 1, 0, 1'b0);
    run(1'b0, 30'h42, 4'hc, 3'h1, 1, 0, 1'b0);
    run(1'b1, 30'h43, 4'h8, 3'h1, 1, 0, 1'b0);
    run(1'b0, 30'h44, 4'h7, 3'h1, 1, 0, 1'b0);
    @(posedge clk_i);
    use0 <= 1'b0;
    use1 <= 1'b1;
    run(1'b1, 30'h45, 4'h3, 3'h1, 1, 0, 1'b0);
    run(1'b0, 30'h47, 4'h0, 3'h2, 2, 0, 1'b0);
    run(1'b0, 30'h48, 4'h0, 3'h4, 4, 0, 1'b1);
    @(posedge clk_i);
    acc <= 1'b1;
    run(1'b0, 30'h50, 4'h0, 3'h4, 1, 3, 1'b1);
    run(1'b1, 30'h52, 4'h0, 3'h2, 1, 1, 1'b1);
    @(posedge clk_i);
    acc <= 1'b0;
    grant_drop();
    run(1'b0, 30'h60, 4'h0, 3'h1, 1, 0, 1'b0);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
